// >>> core/wrs_filt_if.sv
// Purpose: carries a raw level into the noise filter and the clean level back
// Assumes: single clock domain
// Notes: none
`timescale 1ns/10ps
interface wrs_filt_if;
   logic raw;
   logic filt;
   modport filt_side (input raw, output filt);
   modport user_side (output raw, input filt);
endinterface

// >>> core/wrs_filter.sv
// Purpose: noise-cancelling filter; output follows input after DEPTH steady cycles
// Assumes: raw is synchronous to i_clk
// Notes: output resets to inactive
`timescale 1ns/10ps
module wrs_filter
   import wrs_pkg::*;
#(
   parameter int DEPTH = LV_FILT_CYC
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   wrs_filt_if.filt_side fif
);
   localparam int CW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [CW-1:0] LAST = CW'(DEPTH - 1);

   if (DEPTH < 3) begin : g_chk
      $error("filter depth must be at least 3");
   end

   logic [CW-1:0] cnt_r;
   logic filt_r;

   // count cycles in which input disagrees with output
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_r <= '0;
      end else if (fif.raw == filt_r || cnt_r == LAST) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         filt_r <= 1'b0;
      end else if (fif.raw != filt_r && cnt_r == LAST) begin
         filt_r <= fif.raw;
      end
   end

   assign fif.filt = filt_r;

   property p_filt_steady;
      @(posedge i_clk) disable iff (!i_arst_n)
      $rose(filt_r) |-> $past(fif.raw, 1) && $past(fif.raw, 2) && $past(fif.raw, 3);
   endproperty
   a_filt_steady: assert property (p_filt_steady)
      else $error("filter output rose without steady input");
endmodule

// >>> core/wrs_pkg.sv
// Purpose: shared constants of the reset supervisor and watchdog
// Assumes: I_CLK is the oscillator clock; one machine cycle is twelve clocks
// Notes: times are kept in their own unit, cycle counts derive from them
package wrs_pkg;
   // clock
   localparam int CLK_PERIOD_NS = 100;
   localparam int MC_DIV = 12;
   // special function register addresses
   localparam logic [7:0] ADDR_WDOG_RELOAD = 8'h00_A6;
   localparam logic [7:0] ADDR_WDOG_KEY = 8'h00_AE;
   localparam logic [7:0] ADDR_POWER_CTRL = 8'h00_87;
   // field positions and values
   localparam int POWER_CTRL_LV_DIS_BIT = 5;
   localparam int RELOAD_FIELD_W = 7;
   localparam logic [7:0] WDOG_KEY_DISABLE = 8'h00_55;
   localparam logic [7:0] WDOG_KEY_RESET = 8'h00_00;
   localparam logic LV_DIS_RESET = 1'b0;
   // watchdog
   localparam int WDOG_WIDTH = 22;
   localparam int WDOG_PULSE_MC = 32768;
   localparam int WDOG_PULSE_CYC = WDOG_PULSE_MC * MC_DIV;
   // low-voltage detector
   localparam int LV_FILT_NS = 1000;
   localparam int LV_FILT_CYC = (LV_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LV_HOLD_MS = 10;
   localparam int LV_HOLD_CYC = (LV_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // usb bus reset detection
   localparam int USB_SE0_MIN = 4;
   localparam int USB_SE0_LO = 4;
   localparam int USB_SE0_HI = 8;
endpackage

// >>> core/wrs_top.sv
// Purpose: reset supervisor and watchdog; merges four reset sources
// Assumes: SFR bus and pins are synchronous to I_CLK (oscillator clock)
// Notes: no clock gating, so idle and power-down leave this logic running
// Contract
// - internal reset asserts when pin, low voltage, watchdog or usb reset requests
// - internal reset also drives programmable logic module reset, active low
// - low supply resets; reset held 10ms after supply recovers
// - low-voltage reset enabled at power-up; software may disable it afterwards
// - disable control is power control bit 5, writing one disables
// - low-voltage reset logic works in idle and power-down modes
// - low-voltage indication filtered about 1us so short dips are ignored
// - single-ended zero seen 4 to 8 times sets the usb reset flag; the code sets it on consecutive cycle SE0_MIN+1 (5 by default)
// - with usb reset enable set, usb bus reset also resets the device
// - watchdog counter is 22 bits, counts once per machine cycle when enabled
// - watchdog resets the device when counter overflows after 4194304 counts
// - timeout is 12 times 2^22 oscillator periods
// - reload write loads bits 6..0 into the counter's seven top bits
// - writing zero to reload clears the whole counter
// - watchdog disabled only while key holds 55h
// - watchdog enabled at power-up and after every reset
// - watchdog and reset circuitry stay active in idle mode
// - watchdog reset pulse lasts 12 times 2^15 oscillator periods
`timescale 1ns/10ps
module wrs_top
   import wrs_pkg::*;
#(
   parameter int WD_WIDTH = WDOG_WIDTH,
   parameter int WD_PULSE = WDOG_PULSE_CYC,
   parameter int LV_HOLD = LV_HOLD_CYC,
   parameter int LV_FILT = LV_FILT_CYC,
   parameter int SE0_MIN = USB_SE0_MIN
) (
   input wire logic I_CLK,
   input wire logic I_ARST_N,
   input wire logic [7:0] I_SFR_ADDR,
   input wire logic [7:0] I_SFR_WDATA,
   input wire logic I_SFR_WR,
   input wire logic I_SFR_RD,
   output logic [7:0] O_SFR_RDATA,
   input wire logic I_RESET_PIN_N,
   input wire logic I_LV_LOW,
   input wire logic I_USB_SE0,
   input wire logic I_USB_RESET_ENABLE,
   input wire logic I_USB_FLAG_CLR,
   output logic O_USB_RESET_FLAG,
   output logic O_CPU_RST,
   output logic O_PLM_RST_N
);
   localparam int PW = $clog2(WD_PULSE + 1);
   localparam int HW = $clog2(LV_HOLD + 1);
   localparam int SW = $clog2(SE0_MIN + 1);
   localparam int MW = $clog2(MC_DIV);
   localparam logic [MW-1:0] MC_LAST = MW'(MC_DIV - 1);
   localparam logic [PW-1:0] PULSE_LOAD = PW'(WD_PULSE);
   localparam logic [HW-1:0] HOLD_LOAD = HW'(LV_HOLD);
   localparam logic [SW-1:0] SE0_LOAD = SW'(SE0_MIN);

   if (WD_WIDTH < RELOAD_FIELD_W + 1) begin : g_chk_wd
      $error("watchdog width too small for the reload field");
   end
   if (WD_PULSE < 2 || LV_HOLD < 2) begin : g_chk_len
      $error("pulse and hold lengths must be at least 2");
   end
   if (SE0_MIN < USB_SE0_LO || SE0_MIN > USB_SE0_HI) begin : g_chk_se0
      $error("usb single-ended zero count must lie in 4..8");
   end

   logic rst_r;
   logic [MW-1:0] mc_cnt_r;
   logic mc_tick;
   logic [WD_WIDTH-1:0] watchdog_counter;
   logic [7:0] wdog_key_reg;
   logic lv_reset_disable;
   logic wd_enabled;
   logic wd_ovf;
   logic [PW-1:0] wd_pulse_r;
   logic wd_req;
   logic lv_low_f;
   logic [HW-1:0] lv_hold_r;
   logic lv_req;
   logic ext_req;
   logic [SW-1:0] se0_cnt_r;
   logic usb_det;
   logic usb_req;
   logic usb_reset_flag;
   logic wr_reload;
   logic wr_key;
   logic wr_power_ctrl;
   logic [7:0] rdata_nxt;

   assign wr_reload = I_SFR_WR && I_SFR_ADDR == ADDR_WDOG_RELOAD;
   assign wr_key = I_SFR_WR && I_SFR_ADDR == ADDR_WDOG_KEY;
   assign wr_power_ctrl = I_SFR_WR && I_SFR_ADDR == ADDR_POWER_CTRL;

   // low-voltage noise filter
   wrs_filt_if lv_if ();
   assign lv_if.raw = I_LV_LOW;
   assign lv_low_f = lv_if.filt;

   wrs_filter #(
      .DEPTH(LV_FILT)
   ) u_lv_filter (
      .i_clk(I_CLK),
      .i_arst_n(I_ARST_N),
      .fif(lv_if)
   );

   // power control bit 5, cleared by every reset
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         lv_reset_disable <= LV_DIS_RESET;
      end else if (rst_r) begin
         lv_reset_disable <= LV_DIS_RESET;
      end else if (wr_power_ctrl) begin
         lv_reset_disable <= I_SFR_WDATA[POWER_CTRL_LV_DIS_BIT];
      end
   end

   // low-voltage hold: reloads while supply low, counts down after recovery
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         lv_hold_r <= '0;
      end else if (lv_reset_disable) begin
         lv_hold_r <= '0;
      end else if (lv_low_f) begin
         lv_hold_r <= HOLD_LOAD;
      end else if (lv_hold_r != '0) begin
         lv_hold_r <= lv_hold_r - 1'b1;
      end
   end

   assign lv_req = !lv_reset_disable && (lv_low_f || lv_hold_r != '0);

   // external pin request
   assign ext_req = !I_RESET_PIN_N;

   // usb single-ended zero detection
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         se0_cnt_r <= '0;
      end else if (!I_USB_SE0) begin
         se0_cnt_r <= '0;
      end else if (se0_cnt_r != SE0_LOAD) begin
         se0_cnt_r <= se0_cnt_r + 1'b1;
      end
   end

   assign usb_det = I_USB_SE0 && se0_cnt_r == SE0_LOAD;

   // usb reset flag, set wins over clear, survives internal reset
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         usb_reset_flag <= 1'b0;
      end else if (usb_det) begin
         usb_reset_flag <= 1'b1;
      end else if (I_USB_FLAG_CLR) begin
         usb_reset_flag <= 1'b0;
      end
   end

   assign usb_req = usb_det && I_USB_RESET_ENABLE;

   // machine cycle prescaler
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         mc_cnt_r <= '0;
      end else if (rst_r || mc_cnt_r == MC_LAST) begin
         mc_cnt_r <= '0;
      end else begin
         mc_cnt_r <= mc_cnt_r + 1'b1;
      end
   end

   assign mc_tick = mc_cnt_r == MC_LAST;

   // key register, cleared by any reset so the watchdog runs again
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         wdog_key_reg <= WDOG_KEY_RESET;
      end else if (rst_r) begin
         wdog_key_reg <= WDOG_KEY_RESET;
      end else if (wr_key) begin
         wdog_key_reg <= I_SFR_WDATA;
      end
   end

   assign wd_enabled = wdog_key_reg != WDOG_KEY_DISABLE;
   assign wd_ovf = wd_enabled && mc_tick && (&watchdog_counter);

   // watchdog counter
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         watchdog_counter <= '0;
      end else if (rst_r) begin
         watchdog_counter <= '0;
      end else if (wr_reload) begin
         watchdog_counter <= {I_SFR_WDATA[RELOAD_FIELD_W-1:0],
                              {(WD_WIDTH-RELOAD_FIELD_W){1'b0}}};
      end else if (wd_enabled && mc_tick) begin
         watchdog_counter <= watchdog_counter + 1'b1;
      end
   end

   // watchdog reset pulse stretcher
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         wd_pulse_r <= '0;
      end else if (wd_ovf) begin
         wd_pulse_r <= PULSE_LOAD;
      end else if (wd_pulse_r != '0) begin
         wd_pulse_r <= wd_pulse_r - 1'b1;
      end
   end

   assign wd_req = wd_pulse_r != '0;

   // merged internal reset, asserted from power-on
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         rst_r <= 1'b1;
      end else begin
         rst_r <= ext_req || lv_req || wd_req || usb_req;
      end
   end

   assign O_CPU_RST = rst_r;
   assign O_PLM_RST_N = !rst_r;
   assign O_USB_RESET_FLAG = usb_reset_flag;

   // read data: reload reads zero, reserved bits read zero
   always_comb begin
      rdata_nxt = 8'h00_00;
      if (I_SFR_RD && I_SFR_ADDR == ADDR_WDOG_KEY) begin
         rdata_nxt = wdog_key_reg;
      end else if (I_SFR_RD && I_SFR_ADDR == ADDR_POWER_CTRL) begin
         rdata_nxt[POWER_CTRL_LV_DIS_BIT] = lv_reset_disable;
      end
   end

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_SFR_RDATA <= 8'h00_00;
      end else begin
         O_SFR_RDATA <= rdata_nxt;
      end
   end

   // helper: cycles of watchdog request since overflow
   logic [PW-1:0] chk_wd_len_r;
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         chk_wd_len_r <= '0;
      end else if (wd_ovf) begin
         chk_wd_len_r <= '0;
      end else if (wd_req) begin
         chk_wd_len_r <= chk_wd_len_r + 1'b1;
      end
   end

   property p_ext_rst;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      !I_RESET_PIN_N |=> O_CPU_RST;
   endproperty
   a_ext_rst: assert property (p_ext_rst)
      else $error("pin reset did not assert internal reset");

   property p_plm_rst;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      O_PLM_RST_N == !O_CPU_RST;
   endproperty
   a_plm_rst: assert property (p_plm_rst)
      else $error("logic module reset not inverse of internal reset");

   property p_lv_hold;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      $fell(lv_low_f) && !lv_reset_disable && !wr_power_ctrl |=> O_CPU_RST [*8];
   endproperty
   a_lv_hold: assert property (p_lv_hold)
      else $error("reset not held after supply recovery");

   property p_lv_dis;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      lv_reset_disable |-> !lv_req;
   endproperty
   a_lv_dis: assert property (p_lv_dis)
      else $error("low-voltage request while disabled");

   property p_usb_flag;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      I_USB_SE0 && se0_cnt_r == SE0_LOAD |=> O_USB_RESET_FLAG;
   endproperty
   a_usb_flag: assert property (p_usb_flag)
      else $error("usb reset flag not set after single-ended zero");

   property p_usb_rst;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      usb_det && I_USB_RESET_ENABLE |=> O_CPU_RST;
   endproperty
   a_usb_rst: assert property (p_usb_rst)
      else $error("usb bus reset did not reset device");

   property p_wd_ovf;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      wd_ovf |=> ##1 O_CPU_RST && watchdog_counter == '0;
   endproperty
   a_wd_ovf: assert property (p_wd_ovf)
      else $error("watchdog overflow did not reset");

   property p_wd_reload;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      wr_reload && !rst_r |=>
         watchdog_counter[WD_WIDTH-1 -: RELOAD_FIELD_W] ==
         $past(I_SFR_WDATA[RELOAD_FIELD_W-1:0]) && watchdog_counter[0] == 1'b0;
   endproperty
   a_wd_reload: assert property (p_wd_reload)
      else $error("reload value not placed in counter top bits");

   property p_wd_key;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      wdog_key_reg == WDOG_KEY_DISABLE && !wr_reload && !rst_r |=> $stable(watchdog_counter);
   endproperty
   a_wd_key: assert property (p_wd_key)
      else $error("watchdog counted while disabled by key");

   property p_wd_after_rst;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      O_CPU_RST |=> wdog_key_reg != WDOG_KEY_DISABLE;
   endproperty
   a_wd_after_rst: assert property (p_wd_after_rst)
      else $error("watchdog not re-enabled by reset");

   property p_wd_pulse_len;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      $fell(wd_req) && !$past(wd_ovf) |-> chk_wd_len_r == PULSE_LOAD;
   endproperty
   a_wd_pulse_len: assert property (p_wd_pulse_len)
      else $error("watchdog reset pulse has wrong length");

   property p_mc_rate;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      mc_tick |=> !mc_tick [*8];
   endproperty
   a_mc_rate: assert property (p_mc_rate)
      else $error("machine cycle tick too frequent");
endmodule

// >>> dv/watchdog_reset_supervisor_tb.sv
// Purpose: self-checking bench of the reset supervisor and watchdog
// Assumes: shortened counts: 8-bit watchdog, pulse 40, hold 30, filter 3
// Notes: all stimulus changes 1 ns after a rising edge
`timescale 1ns/10ps
module watchdog_reset_supervisor_tb;
   import wrs_pkg::*;
   localparam int WDW = 8;
   localparam int PULSE = 40;
   localparam int HOLD = 30;
   localparam int TMO = (2 ** WDW) * MC_DIV;
   logic clk;
   logic arst_n;
   logic pin_n;
   logic lv_low;
   logic se0;
   logic usb_en;
   logic flag_clr;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [7:0] rd_val;
   logic wr;
   logic rd;
   logic flag;
   logic cpu_rst;
   logic plm_rst_n;
   int fails;
   int comparisons;
   int n;

   wrs_top #(.WD_WIDTH(WDW), .WD_PULSE(PULSE), .LV_HOLD(HOLD), .LV_FILT(3), .SE0_MIN(4))
   u_wrs_top (
      .I_CLK(clk), .I_ARST_N(arst_n), .I_SFR_ADDR(addr), .I_SFR_WDATA(wdata),
      .I_SFR_WR(wr), .I_SFR_RD(rd), .O_SFR_RDATA(rdata), .I_RESET_PIN_N(pin_n),
      .I_LV_LOW(lv_low), .I_USB_SE0(se0), .I_USB_RESET_ENABLE(usb_en),
      .I_USB_FLAG_CLR(flag_clr), .O_USB_RESET_FLAG(flag), .O_CPU_RST(cpu_rst),
      .O_PLM_RST_N(plm_rst_n)
   );

   wrs_cpu_model u_wrs_cpu_model (
      .i_clk(clk), .i_sfr_rdata(rdata), .o_sfr_addr(addr), .o_sfr_wdata(wdata),
      .o_sfr_wr(wr), .o_sfr_rd(rd)
   );

   task automatic complete_run();
      $display("counts: comparisons %0d, fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic step(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk1(input string nm, input logic e, input logic g);
      chk(nm, {7'h00, e}, {7'h00, g});
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string nm);
      u_wrs_cpu_model.sfr_rd(a, rd_val);
      chk(nm, e, rd_val);
   endtask

   // bounded wait for the internal reset to reach level v
   task automatic wait_rst(input logic v, input int lim, output int c);
      c = 0;
      while (cpu_rst !== v && c < lim) begin
         step(1);
         c++;
      end
      if (cpu_rst !== v) begin
         fails++;
         $display("MISMATCH reset_wait expected %b seen %b", v, cpu_rst);
         complete_run();
      end
   endtask

   // the internal reset must stay low for c cycles
   task automatic quiet(input int c);
      logic seen;
      seen = 1'b0;
      repeat (c) begin
         step(1);
         if (cpu_rst !== 1'b0) seen = 1'b1;
      end
      chk1("reset_seen", 1'b0, seen);
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      arst_n = 1'b0;
      pin_n = 1'b0;
      lv_low = 1'b0;
      se0 = 1'b0;
      usb_en = 1'b0;
      flag_clr = 1'b0;
      fails = 0;
      comparisons = 0;
      step(2);
      arst_n = 1'b1;
      step(10000);
      chk1("cpu_rst_pin", 1'b1, cpu_rst);
      chk1("plm_rst_n_pin", 1'b0, plm_rst_n);
      pin_n = 1'b1;
      wait_rst(1'b0, 4, n);
      chk1("plm_rst_n_run", 1'b1, plm_rst_n);
      rdchk(ADDR_WDOG_KEY, WDOG_KEY_RESET, "key_reset");
      rdchk(ADDR_POWER_CTRL, 8'h00, "power_ctrl_reset");
      rdchk(ADDR_WDOG_RELOAD, 8'h00, "reload_read");
      rdchk(8'h55, 8'h00, "unmapped_read");
      $display("test power_up done");

      step(TMO - 600);
      u_wrs_cpu_model.sfr_wr(ADDR_WDOG_RELOAD, 8'h00);
      quiet(TMO - 600);
      wait_rst(1'b1, 700, n);
      chk1("timeout_period", 1'b1, n >= 580 && n <= 620);
      wait_rst(1'b0, 200, n);
      chk("wdog_pulse_width", 8'(PULSE), 8'(n));
      u_wrs_cpu_model.sfr_wr(ADDR_WDOG_RELOAD, 8'h7E);
      wait_rst(1'b1, 80, n);
      chk1("reload_top_bits", 1'b1, n >= 30);
      wait_rst(1'b0, 200, n);
      $display("test watchdog done");

      u_wrs_cpu_model.sfr_wr(ADDR_WDOG_KEY, WDOG_KEY_DISABLE);
      rdchk(ADDR_WDOG_KEY, WDOG_KEY_DISABLE, "key_readback");
      u_wrs_cpu_model.sfr_wr(8'hAF, 8'h00);
      quiet(TMO + 100);
      u_wrs_cpu_model.sfr_wr(ADDR_WDOG_KEY, 8'h54);
      wait_rst(1'b1, TMO + 50, n);
      wait_rst(1'b0, 200, n);
      rdchk(ADDR_WDOG_KEY, WDOG_KEY_RESET, "key_after_reset");
      $display("test key done");

      lv_low = 1'b1;
      step(2);
      lv_low = 1'b0;
      quiet(20);
      lv_low = 1'b1;
      step(10);
      chk1("lv_reset", 1'b1, cpu_rst);
      lv_low = 1'b0;
      wait_rst(1'b0, 60, n);
      chk1("lv_hold_window", 1'b1, n >= HOLD && n <= HOLD + 8);
      u_wrs_cpu_model.sfr_wr(ADDR_POWER_CTRL, 8'hFF);
      rdchk(ADDR_POWER_CTRL, 8'h20, "power_ctrl_bit");
      lv_low = 1'b1;
      quiet(20);
      lv_low = 1'b0;
      step(5);
      $display("test low_voltage done");

      se0 = 1'b1;
      step(4);
      se0 = 1'b0;
      step(2);
      chk1("flag_short_se0", 1'b0, flag);
      se0 = 1'b1;
      quiet(8);
      se0 = 1'b0;
      step(1);
      chk1("flag_set", 1'b1, flag);
      flag_clr = 1'b1;
      step(1);
      flag_clr = 1'b0;
      step(1);
      chk1("flag_clear", 1'b0, flag);
      flag_clr = 1'b1;
      se0 = 1'b1;
      step(5);
      se0 = 1'b0;
      flag_clr = 1'b0;
      step(1);
      chk1("flag_set_over_clear", 1'b1, flag);
      usb_en = 1'b1;
      se0 = 1'b1;
      step(7);
      chk1("usb_reset", 1'b1, cpu_rst);
      se0 = 1'b0;
      wait_rst(1'b0, 4, n);
      $display("test usb done");
      complete_run();
   end
endmodule

// >>> dv/wrs_cpu_model.sv
// Purpose: processor-side model that issues sfr writes and reads
// Assumes: every task is entered just after a rising edge of i_clk
// Notes: a released bus shows the inverse of its last address and data
`timescale 1ns/10ps
module wrs_cpu_model (
   input wire logic i_clk,
   input wire logic [7:0] i_sfr_rdata,
   output logic [7:0] o_sfr_addr,
   output logic [7:0] o_sfr_wdata,
   output logic o_sfr_wr,
   output logic o_sfr_rd
);
   initial begin
      o_sfr_addr = 8'h00;
      o_sfr_wdata = 8'h00;
      o_sfr_wr = 1'b0;
      o_sfr_rd = 1'b0;
   end

   // one-cycle write strobe, taken at the next rising edge, then one idle cycle
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      o_sfr_addr = a;
      o_sfr_wdata = d;
      o_sfr_wr = 1'b1;
      @(posedge i_clk);
      #1;
      o_sfr_wr = 1'b0;
      o_sfr_addr = ~a;
      o_sfr_wdata = ~d;
      @(posedge i_clk);
      #1;
   endtask

   // read data is registered, so it is taken one cycle after the strobe
   task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
      o_sfr_addr = a;
      o_sfr_rd = 1'b1;
      @(posedge i_clk);
      #1;
      o_sfr_rd = 1'b0;
      o_sfr_addr = ~a;
      d = i_sfr_rdata;
      @(posedge i_clk);
      #1;
   endtask
endmodule
